//--- prf_framer.sv
// particle record framer: ahb-lite registers, record sequencer, serial output
`timescale 1ns/10ps
module prf_framer
  import prf_pkg::*;
#(
  parameter int BAUD_DIV_P = BAUD_DIV
)(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // optical link
  output logic             serial_txd,
  // front panel and status
  output logic [11:0]      error_display,
  output logic             message_busy
);

  // ************************************************************
  // decoding helpers
  // ************************************************************
  function automatic logic addr_mapped(input logic [31:0] a);
    return (a[31:7] == 25'h0) && (a[1:0] == 2'b00) && (a[6:2] < 5'(NUM_REGS));
  endfunction : addr_mapped

  function automatic logic [7:0] hex_ascii(input logic [3:0] n);
    return (n < 4'hA) ? (CHR_ZERO + 8'(n)) : (CHR_HEXA + 8'(n));
  endfunction : hex_ascii

  function automatic logic [7:0] field_letter(input logic [4:0] f);
    logic [7:0] base;
    base = CHR_LET_A;
    if (f >= GRP_D_FIRST)
      base = CHR_LET_A + 8'h03;
    else if (f >= GRP_C_FIRST)
      base = CHR_LET_A + 8'h02;
    else if (f >= GRP_B_FIRST)
      base = CHR_LET_A + 8'h01;
    return base;
  endfunction : field_letter

  function automatic logic [7:0] field_digit(input logic [4:0] f);
    logic [4:0] first;
    first = 5'd0;
    if (f >= GRP_D_FIRST)
      first = GRP_D_FIRST;
    else if (f >= GRP_C_FIRST)
      first = GRP_C_FIRST;
    else if (f >= GRP_B_FIRST)
      first = GRP_B_FIRST;
    return CHR_ONE + {3'b000, f - first};
  endfunction : field_digit

  // data characters per field
  function automatic logic [2:0] field_len(input logic [4:0] f);
    logic [2:0] n;
    case (f)
      5'd0, 5'd2:                   n = 3'd4;
      5'd1, 5'd3:                   n = 3'd2;
      5'd4, 5'd5, 5'd6, 5'd7:       n = 3'd7;
      5'd8, 5'd9:                   n = 3'd6;
      5'd10:                        n = 3'd3;
      5'd11, 5'd12, 5'd13, 5'd14:   n = 3'd4;
      5'd15, 5'd16, 5'd17, 5'd18:   n = 3'd3;
      5'd19:                        n = 3'd2;
      5'd20:                        n = 3'd3;
      5'd21:                        n = 3'd2;
      5'd22:                        n = 3'd2;
      default:                      n = 3'd1;
    endcase
    return n;
  endfunction : field_len

  // counts are held in thousandths of a count per ml
  function automatic logic [15:0] scale_count(input logic [31:0] milli, input logic [15:0] code);
    logic [31:0] v;
    if (code < CODE_LOW_BAND)
      v = milli;
    else if (code <= CODE_HIGH_BAND)
      v = milli / MILLI;
    else
      v = milli / MICRO_INV;
    return v[15:0];
  endfunction : scale_count

  // ************************************************************
  // registers and bus slave
  // ************************************************************
  logic [31:0] regs_r [NUM_REGS];
  logic        wr_pend_r;
  logic [4:0]  wr_idx_r;
  logic        acc;
  logic        wr_ok;
  logic        send_req;
  logic [31:0] rd_word;
  logic [31:0] status_w;
  logic [15:0] msg_count_r;
  logic [7:0]  alarm_bits;
  logic [4:0]  rd_idx;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel && htrans[1] && hready;
  assign rd_idx    = haddr[6:2];
  // data registers are frozen while a record is on the line so it stays self-consistent
  assign wr_ok     = wr_pend_r && (wr_idx_r >= FIRST_DATA) && !message_busy;
  assign send_req  = wr_pend_r && (wr_idx_r == REG_CTRL[6:2]) && hwdata[CTRL_SEND];

  always_comb
  begin
    status_w                         = 32'h00000000;
    status_w[STAT_BUSY]              = message_busy;
    status_w[STAT_ALARM +: 8]        = alarm_bits;
    status_w[STAT_COUNT +: 16]       = msg_count_r;
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    if (!addr_mapped(haddr))
      rd_word = 32'h00000000;
    else if (rd_idx == REG_STAT[6:2])
      rd_word = status_w;
    else if (rd_idx >= FIRST_DATA)
      rd_word = (wr_ok && (wr_idx_r == rd_idx)) ? hwdata : regs_r[rd_idx];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 5'h00;
    end
    else
    begin
      wr_pend_r <= acc && hwrite && addr_mapped(haddr);
      wr_idx_r  <= rd_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (acc && !hwrite)
      hrdata <= rd_word;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_r[i] <= 32'h00000000;
    end
    else if (wr_ok)
    begin
      regs_r[wr_idx_r] <= hwdata;
    end
  end

  // ************************************************************
  // alarm limits and display
  // ************************************************************
  prf_alarm_check u_alarm (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .laser_drive_level (regs_r[IDX_LASER][7:0]),
    .power_cv          (regs_r[IDX_POWER][15:0]),
    .temp_c            (regs_r[IDX_TEMP][7:0]),
    .flow_index        (regs_r[IDX_FLOW][15:0]),
    .clean_code_ch1    (regs_r[IDX_CODE1][15:0]),
    .alarm_bits        (alarm_bits)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      error_display <= 12'h000;
    else
      error_display <= {4'h0, alarm_bits};
  end

  // ************************************************************
  // record sequencer
  // ************************************************************
  prf_state_t  state_r;
  prf_state_t  state_nxt;
  logic [4:0]  fld_r;
  logic [2:0]  dig_r;
  logic [7:0]  csum_r;
  logic [7:0]  tx_byte;
  logic        tx_valid;
  logic        tx_ready;
  logic        fire;
  logic [27:0] fval;
  logic [2:0]  flen;
  logic [4:0]  pos;
  logic [3:0]  nib;
  logic        last_dig;

  assign tx_valid     = (state_r != ST_IDLE);
  assign fire         = tx_valid && tx_ready;
  assign message_busy = (state_r != ST_IDLE) || !tx_ready;
  assign flen         = field_len(fld_r);
  assign last_dig     = (dig_r == flen - 3'd1);
  assign pos          = {2'b00, flen - 3'd1 - dig_r};
  assign nib          = 4'(fval >> {pos, 2'b00});

  // value of the field being sent; digits above its length are never picked
  always_comb
  begin
    fval = regs_r[fld_r + FIRST_DATA][27:0];
    if (fld_r >= GRP_C_FIRST && fld_r < FLD_CODE1)
      fval = {12'h000, scale_count(regs_r[fld_r + FIRST_DATA],
                                   regs_r[fld_r + FIRST_DATA + 5'd4][15:0])};
    else if (fld_r == FLD_ALARM)
      fval = {20'h00000, alarm_bits};
  end

  always_comb
  begin
    tx_byte = CHR_START;
    case (state_r)
      ST_START:  tx_byte = CHR_START;
      ST_ID0:    tx_byte = field_letter(fld_r);
      ST_ID1:    tx_byte = field_digit(fld_r);
      ST_DATA:   tx_byte = hex_ascii(nib);
      ST_CSUM_H: tx_byte = hex_ascii(csum_r[7:4]);
      ST_CSUM_L: tx_byte = hex_ascii(csum_r[3:0]);
      ST_CR:     tx_byte = CHR_CR;
      ST_LF:     tx_byte = CHR_LF;
      default:   tx_byte = CHR_START;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (send_req && tx_ready)
          state_nxt = ST_START;
      ST_START:
        if (fire)
          state_nxt = ST_ID0;
      ST_ID0:
        if (fire)
          state_nxt = ST_ID1;
      ST_ID1:
        if (fire)
          state_nxt = ST_DATA;
      ST_DATA:
        if (fire && last_dig)
          state_nxt = (fld_r == NUM_FIELDS - 5'd1) ? ST_CSUM_H : ST_ID0;
      ST_CSUM_H:
        if (fire)
          state_nxt = ST_CSUM_L;
      ST_CSUM_L:
        if (fire)
          state_nxt = ST_CR;
      ST_CR:
        if (fire)
          state_nxt = ST_LF;
      ST_LF:
        if (fire)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fld_r <= 5'd0;
      dig_r <= 3'd0;
    end
    else if (state_r == ST_IDLE)
    begin
      fld_r <= 5'd0;
      dig_r <= 3'd0;
    end
    else if (fire && state_r == ST_DATA)
    begin
      dig_r <= last_dig ? 3'd0 : dig_r + 3'd1;
      if (last_dig)
        fld_r <= fld_r + 5'd1;
    end
  end

  // checksum covers the start marker through the last data digit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      csum_r <= 8'h00;
    else if (state_r == ST_IDLE)
      csum_r <= 8'h00;
    else if (fire && (state_r == ST_START || state_r == ST_ID0 || state_r == ST_ID1 || state_r == ST_DATA))
      csum_r <= csum_r + tx_byte;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      msg_count_r <= 16'h0000;
    else if (fire && state_r == ST_LF)
      msg_count_r <= msg_count_r + 16'h0001;
  end

  // ************************************************************
  // serial line
  // ************************************************************
  prf_uart_tx #(
    .DIV (BAUD_DIV_P)
  ) u_tx (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tx_data  (tx_byte),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .txd      (serial_txd)
  );

endmodule : prf_framer

//--- prf_pkg.sv
// shared constants and types for the particle record serial framer
package prf_pkg;

  // ************************************************************
  // link timing
  // ************************************************************
  localparam int CLK_HZ    = 40_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_DIV  = CLK_HZ / BAUD_RATE;

  // ************************************************************
  // register map (byte offsets)
  // ************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_SYS_ID = 8'h08;
  localparam logic [7:0] REG_RSV1   = 8'h18;
  localparam logic [7:0] REG_STIME  = 8'h30;
  localparam logic [7:0] REG_COUNT1 = 8'h34;
  localparam logic [7:0] REG_CODE1  = 8'h44;
  localparam logic [7:0] REG_LASER  = 8'h54;
  localparam logic [7:0] REG_POWER  = 8'h58;
  localparam logic [7:0] REG_TEMP   = 8'h5C;
  localparam logic [7:0] REG_FLOW   = 8'h60;
  localparam int         NUM_REGS   = 25;
  localparam logic [4:0] FIRST_DATA = 5'h02;
  localparam logic [4:0] IDX_LASER  = 5'h15;
  localparam logic [4:0] IDX_POWER  = 5'h16;
  localparam logic [4:0] IDX_TEMP   = 5'h17;
  localparam logic [4:0] IDX_FLOW   = 5'h18;
  localparam logic [4:0] IDX_CODE1  = 5'h11;
  localparam int         CTRL_SEND  = 0;
  localparam int         STAT_BUSY  = 0;
  localparam int         STAT_ALARM = 8;
  localparam int         STAT_COUNT = 16;

  // ************************************************************
  // characters
  // ************************************************************
  localparam logic [7:0] CHR_START = 8'h3B;
  localparam logic [7:0] CHR_CR    = 8'h0D;
  localparam logic [7:0] CHR_LF    = 8'h0A;
  localparam logic [7:0] CHR_ZERO  = 8'h30;
  localparam logic [7:0] CHR_ONE   = 8'h31;
  localparam logic [7:0] CHR_HEXA  = 8'h37;
  localparam logic [7:0] CHR_LET_A = 8'h41;

  // ************************************************************
  // record layout: field index, register index is field + 2
  // ************************************************************
  localparam logic [4:0] NUM_FIELDS  = 5'd23;
  localparam logic [4:0] GRP_B_FIRST = 5'd4;
  localparam logic [4:0] GRP_C_FIRST = 5'd11;
  localparam logic [4:0] GRP_D_FIRST = 5'd19;
  localparam logic [4:0] FLD_CODE1   = 5'd15;
  localparam logic [4:0] FLD_ALARM   = 5'd22;

  // ************************************************************
  // scaling and alarm limits
  // ************************************************************
  localparam logic [15:0] CODE_LOW_BAND  = 16'h006E;
  localparam logic [15:0] CODE_HIGH_BAND = 16'h00EC;
  localparam logic [31:0] MILLI          = 32'h000003E8;
  localparam logic [31:0] MICRO_INV      = 32'h000F4240;
  localparam logic [7:0]  LASER_MIN      = 8'h1E;
  localparam logic [7:0]  LASER_MAX      = 8'h3E;
  localparam logic [15:0] POWER_MIN      = 16'h01D6;
  localparam logic [15:0] POWER_MAX      = 16'h01EA;
  localparam logic signed [7:0] TEMP_MIN = -8'sh14;
  localparam logic signed [7:0] TEMP_MAX = 8'sh50;
  localparam logic [15:0] FLOW_MIN       = 16'h0028;
  localparam logic [15:0] FLOW_MAX       = 16'h015E;
  localparam logic [15:0] CONC_MAX_CODE  = 16'h0118;
  localparam int ALM_LASER_LO = 0;
  localparam int ALM_LASER_HI = 1;
  localparam int ALM_POWER_LO = 2;
  localparam int ALM_POWER_HI = 3;
  localparam int ALM_TEMP_LO  = 4;
  localparam int ALM_TEMP_HI  = 5;
  localparam int ALM_CONC     = 6;
  localparam int ALM_FLOW     = 7;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'b000000001,
    ST_START  = 9'b000000010,
    ST_ID0    = 9'b000000100,
    ST_ID1    = 9'b000001000,
    ST_DATA   = 9'b000010000,
    ST_CSUM_H = 9'b000100000,
    ST_CSUM_L = 9'b001000000,
    ST_CR     = 9'b010000000,
    ST_LF     = 9'b100000000
  } prf_state_t;

endpackage : prf_pkg

//--- prf_uart_tx.sv
// serial character transmitter, 8 data bits lsb first, one stop, no parity
`timescale 1ns/10ps
module prf_uart_tx
  import prf_pkg::*;
#(
  parameter int DIV = BAUD_DIV
)(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // character in
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // line
  output logic            txd
);

  logic [9:0]  shift_r;
  logic [3:0]  bits_r;
  logic [15:0] baud_r;

  assign tx_ready = (bits_r == 4'h0);
  assign txd      = shift_r[0];

  // line idles high; the stop bit stands a full period before ready returns
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_r <= 10'h3FF;
      bits_r  <= 4'h0;
      baud_r  <= 16'h0000;
    end
    else if (tx_valid && tx_ready)
    begin
      shift_r <= {1'b1, tx_data, 1'b0};
      bits_r  <= 4'hA;
      baud_r  <= 16'(DIV - 1);
    end
    else if (bits_r != 4'h0)
    begin
      if (baud_r == 16'h0000)
      begin
        shift_r <= {1'b1, shift_r[9:1]};
        bits_r  <= bits_r - 4'h1;
        baud_r  <= 16'(DIV - 1);
      end
      else
      begin
        baud_r <= baud_r - 16'h0001;
      end
    end
  end

endmodule : prf_uart_tx

//--- prf_alarm_check.sv
// alarm bitmap from diagnostics against fixed limits
`timescale 1ns/10ps
module prf_alarm_check
  import prf_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // measurements
  input  wire logic [7:0]  laser_drive_level,
  input  wire logic [15:0] power_cv,
  input  wire logic [7:0]  temp_c,
  input  wire logic [15:0] flow_index,
  input  wire logic [15:0] clean_code_ch1,
  // result
  output logic [7:0]       alarm_bits
);

  logic [7:0] alarm_nxt;

  always_comb
  begin
    alarm_nxt               = 8'h00;
    alarm_nxt[ALM_LASER_LO] = laser_drive_level < LASER_MIN;
    alarm_nxt[ALM_LASER_HI] = laser_drive_level > LASER_MAX;
    alarm_nxt[ALM_POWER_LO] = power_cv < POWER_MIN;
    alarm_nxt[ALM_POWER_HI] = power_cv > POWER_MAX;
    alarm_nxt[ALM_TEMP_LO]  = $signed(temp_c) < TEMP_MIN;
    alarm_nxt[ALM_TEMP_HI]  = $signed(temp_c) > TEMP_MAX;
    alarm_nxt[ALM_CONC]     = clean_code_ch1 > CONC_MAX_CODE;
    alarm_nxt[ALM_FLOW]     = (flow_index < FLOW_MIN) || (flow_index > FLOW_MAX);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alarm_bits <= 8'h00;
    else
      alarm_bits <= alarm_nxt;
  end

endmodule : prf_alarm_check

//--- prf_framer_properties.sv
// port assertions for the record framer
`timescale 1ns/10ps
module prf_framer_props
  import prf_pkg::*;
#(
  parameter int BAUD_DIV_P = BAUD_DIV
)(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  // outputs
  input wire logic        serial_txd,
  input wire logic [11:0] error_display,
  input wire logic        message_busy
);
  // ********
  // helpers
  // ********
  // 143 characters, ten bit times each plus the reload cycle
  localparam int MSG_CHARS = 143;
  logic [15:0] run_r;
  logic        last_r;
  logic [23:0] busy_cnt_r;
  logic        ctrl_wr;
  assign ctrl_wr = hsel && htrans[1] && hwrite && (haddr == 32'h0);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r  <= 16'h0;
      last_r <= 1'h1;
    end
    else
    begin
      run_r  <= (serial_txd != last_r) ? 16'h1 : run_r + 16'h1;
      last_r <= serial_txd;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_cnt_r <= 24'h0;
    else
      busy_cnt_r <= message_busy ? busy_cnt_r + 24'h1 : 24'h0;
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_idle_high;
    !message_busy |-> serial_txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");
  property p_low_run;
    $rose(serial_txd) |-> run_r >= BAUD_DIV_P && run_r % BAUD_DIV_P == 0;
  endproperty
  a_low_run: assert property (p_low_run) else $error("bit time broken");
  property p_start_char;
    $rose(message_busy) |-> serial_txd ##1 (!serial_txd) [*4] ##1 serial_txd [*4] ##1 serial_txd [*4] ##1 !serial_txd;
  endproperty
  a_start_char: assert property (p_start_char) else $error("first character wrong");
  property p_second_char;
    $rose(message_busy) |-> ##42 (!serial_txd) [*4] ##1 serial_txd [*4] ##1 (!serial_txd) [*8];
  endproperty
  a_second_char: assert property (p_second_char) else $error("second character wrong");
  property p_lf_end;
    $fell(message_busy) |-> $past(serial_txd) && $past(serial_txd, 4) && !$past(serial_txd, 5) && !$past(serial_txd, 8);
  endproperty
  a_lf_end: assert property (p_lf_end) else $error("record does not end in line feed");
  property p_msg_len;
    $fell(message_busy) |-> busy_cnt_r == MSG_CHARS * (10 * BAUD_DIV_P + 1);
  endproperty
  a_msg_len: assert property (p_msg_len) else $error("record length wrong");
  property p_busy_start;
    $rose(message_busy) |-> $past(ctrl_wr, 2) && $past(hwdata[0], 1);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("record without send");
  property p_display_top;
    error_display[11:8] == 4'h0;
  endproperty
  a_display_top: assert property (p_display_top) else $error("display top digit set");
endmodule : prf_framer_props

bind prf_framer prf_framer_props #(.BAUD_DIV_P(BAUD_DIV_P)) prf_framer_props_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .serial_txd(serial_txd), .error_display(error_display), .message_busy(message_busy));

//--- prf_link_rx.sv
// serial receiver standing in for the interface module
`timescale 1ns/10ps
module prf_link_rx
#(
  parameter int DIV = 4
)(
  // clock
  input  wire logic       hclk,
  // line
  input  wire logic       rxd,
  // received character
  output logic [7:0]      rx_byte,
  output logic            rx_stb,
  output logic            rx_ferr
);
  initial
  begin
    rx_byte = 8'h0;
    rx_stb  = 1'h0;
    rx_ferr = 1'h0;
  end
  // mid-bit sampling, no kinder than a real receiver
  always
  begin
    @(posedge hclk);
    rx_stb <= 1'h0;
    if (rxd === 1'h0)
    begin
      repeat (DIV / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (DIV) @(posedge hclk);
        rx_byte[i] <= rxd;
      end
      repeat (DIV) @(posedge hclk);
      rx_ferr <= (rxd !== 1'h1);
      rx_stb  <= 1'h1;
    end
  end
endmodule : prf_link_rx

//--- tb_top.sv
// self-checking bench for the record framer
`timescale 1ns/10ps
module tb_top
  import prf_pkg::*;
;
  typedef struct packed {logic [7:0] laser; logic [15:0] power; logic [7:0] temp;
                         logic [15:0] flow; logic [15:0] code1; logic [7:0] alarm;} prf_row_t;
  localparam int DIV = 4;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        serial_txd;
  logic [11:0] error_display;
  logic        message_busy;
  logic [7:0]  rx_byte;
  logic        rx_stb;
  logic        rx_ferr;
  int          miscompares;
  int          compares;
  logic [7:0]  rxq[$];
  logic [7:0]  expq[$];
  logic [31:0] fv[23];
  int          nd[23] = '{4, 2, 4, 2, 7, 7, 7, 7, 6, 6, 3, 4, 4, 4, 4, 3, 3, 3, 3, 2, 3, 2, 2};
  logic [31:0] wv[22] = '{32'h2107, 32'h8A, 32'h4DF, 32'h1C, 32'hABCDEF1, 32'h1234567, 32'h0, 32'hFFFFFFF,
                          32'h3D8, 32'hFEDCBA, 32'hE0F, 32'h3B9ACA00, 32'hABCD, 32'h1E240, 32'hFFFFFFFF,
                          32'h116, 32'h6D, 32'h6E, 32'hED, 32'h30, 32'h1E3, 32'hEC};
  prf_row_t    rows[5] = '{
    '{8'h1E, 16'h1D6, 8'hEC, 16'h28, 16'h118, 8'h00},
    '{8'h3E, 16'h1EA, 8'h50, 16'h15E, 16'h118, 8'h00},
    '{8'h1D, 16'h1D5, 8'hEB, 16'h27, 16'h119, 8'hD5},
    '{8'h3F, 16'h1EB, 8'h51, 16'h15F, 16'h118, 8'hAA},
    '{8'h3F, 16'h1D5, 8'h1F, 16'h82, 16'hCA, 8'h06}};

  prf_framer #(.BAUD_DIV_P(DIV)) prf_framer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .serial_txd(serial_txd), .error_display(error_display), .message_busy(message_busy));
  prf_link_rx #(.DIV(DIV)) prf_link_rx_inst (
    .hclk(hclk), .rxd(serial_txd), .rx_byte(rx_byte), .rx_stb(rx_stb), .rx_ferr(rx_ferr));

  always #12.5 hclk = ~hclk;

  always @(posedge hclk)
    if (rx_stb === 1'h1)
    begin
      rxq.push_back(rx_byte);
      check("stop bit", 32'(rx_ferr), 32'h0);
    end

  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= 32'(a);
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    logic [31:0] d;
    bus(1'h0, a, 32'h0, d);
    check("hresp", 32'(hresp), 32'h0);
    check(what, d & m, e);
  endtask : rd_chk

  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : hexc

  task automatic build_exp;
    logic [7:0] sum;
    int         k;
    expq = {8'h3B};
    for (int f = 0; f < 23; f++)
    begin
      k = (f < 4) ? f : (f < 11) ? f - 4 : (f < 19) ? f - 11 : f - 19;
      expq.push_back((f < 4) ? 8'h41 : (f < 11) ? 8'h42 : (f < 19) ? 8'h43 : 8'h44);
      expq.push_back(8'h31 + 8'(k));
      for (int d = nd[f] - 1; d >= 0; d--)
        expq.push_back(hexc(fv[f][d * 4 +: 4]));
    end
    sum = 8'h0;
    foreach (expq[i])
      sum += expq[i];
    expq.push_back(hexc(sum[7:4]));
    expq.push_back(hexc(sum[3:0]));
    expq.push_back(8'h0D);
    expq.push_back(8'h0A);
  endtask : build_exp

  // second send and data write land mid-record and must be refused
  task automatic send_msg(input logic [15:0] cnt);
    int n;
    n = 0;
    rxq.delete();
    wr(8'h00, 32'h1);
    rd_chk(8'h04, 32'h1, 32'h1, "busy");
    wr(8'h08, 32'h5555);
    wr(8'h00, 32'h1);
    while (message_busy !== 1'h0 && n < 20000)
    begin
      @(posedge hclk);
      n++;
    end
    repeat (50) @(posedge hclk);
    check("length", rxq.size(), expq.size());
    foreach (expq[i])
      check("char", rxq[i], expq[i]);
    rd_chk(8'h04, 32'hFFFFFF01, {cnt, 16'h8000}, "sent");
    if (n >= 20000)
    begin
      miscompares++;
      print_verdict();
    end
  endtask : send_msg

  // ********
  // sequence
  // ********
  initial
  begin
    hclk        = 1'h0;
    hresetn     = 1'h0;
    hsel        = 1'h0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'h0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    miscompares = 0;
    compares    = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (4) @(posedge hclk);
    check("txd idle", 32'(serial_txd), 32'h1);
    check("busy idle", 32'(message_busy), 32'h0);
    check("reset display", 32'(error_display), 32'h85);
    rd_chk(8'h04, 32'hFFFFFFFF, 32'h8500, "reset stat");
    rd_chk(8'h64, 32'hFFFFFFFF, 32'h0, "unmapped");
    foreach (rows[i])
    begin
      wr(REG_LASER, 32'(rows[i].laser));
      wr(REG_POWER, 32'(rows[i].power));
      wr(REG_TEMP, 32'(rows[i].temp));
      wr(REG_FLOW, 32'(rows[i].flow));
      wr(REG_CODE1, 32'(rows[i].code1));
      repeat (3) @(posedge hclk);
      check("display", 32'(error_display), 32'(rows[i].alarm));
      rd_chk(8'h04, 32'hFF00, {16'h0, rows[i].alarm, 8'h0}, "stat alarm");
    end
    foreach (wv[f])
    begin
      wr(8'h08 + 8'(4 * f), wv[f]);
      fv[f] = wv[f];
    end
    wr(REG_FLOW, 32'h1C);
    fv[22] = 32'h80;
    for (int c = 0; c < 4; c++)
      fv[11 + c] = (wv[15 + c] < 32'h6E) ? wv[11 + c] :
                   (wv[15 + c] <= 32'hEC) ? wv[11 + c] / 32'h3E8 : wv[11 + c] / 32'hF4240;
    build_exp();
    send_msg(16'h1);
    rd_chk(8'h08, 32'hFFFFFFFF, 32'h2107, "held field");
    send_msg(16'h2);
    print_verdict();
  end
endmodule : tb_top
